//--- nvc_pkg.sv
package nvc_pkg;

  // command opcodes
  localparam logic [1:0] NVC_OP_READ   = 2'h0;
  localparam logic [1:0] NVC_OP_WRITE  = 2'h1;
  localparam logic [1:0] NVC_OP_STORE  = 2'h2;
  localparam logic [1:0] NVC_OP_RECALL = 2'h3;

  localparam int NVC_AW = 15;
  localparam int NVC_DW = 8;
  localparam int NVC_TW = 17;

  typedef struct packed {
    logic [1:0]        op;
    logic [NVC_AW-1:0] addr;
    logic [NVC_DW-1:0] wdata;
  } nvc_cmd_t;

  // software sequence words, low fourteen address bits
  localparam logic [13:0] NVC_SEQ_A0     = 14'h0e38;
  localparam logic [13:0] NVC_SEQ_A1     = 14'h31c7;
  localparam logic [13:0] NVC_SEQ_A2     = 14'h03e0;
  localparam logic [13:0] NVC_SEQ_A3     = 14'h3c1f;
  localparam logic [13:0] NVC_SEQ_A4     = 14'h303f;
  localparam logic [13:0] NVC_SEQ_STORE  = 14'h0fc0;
  localparam logic [13:0] NVC_SEQ_RECALL = 14'h0c63;
  localparam logic [2:0]  NVC_SEQ_LAST   = 3'h5;

  // timing
  localparam int NVC_CLK_KHZ      = 10000;
  localparam int NVC_T_STORE_US   = 10000;
  localparam int NVC_T_RECALL_US  = 20;
  localparam int NVC_T_RESTORE_US = 650;
  localparam int NVC_STORE_CYC    = NVC_T_STORE_US * NVC_CLK_KHZ / 1000;
  localparam int NVC_RECALL_CYC   = NVC_T_RECALL_US * NVC_CLK_KHZ / 1000;
  localparam int NVC_RESTORE_CYC  = NVC_T_RESTORE_US * NVC_CLK_KHZ / 1000;
  // strobe low time; covers slowest access plus margin
  localparam logic [2:0] NVC_ACC_CYC = 3'h3;

  typedef enum logic [5:0] {
    NVC_S_PWR   = 6'h01,
    NVC_S_IDLE  = 6'h02,
    NVC_S_SETUP = 6'h04,
    NVC_S_ACC   = 6'h08,
    NVC_S_HOLD  = 6'h10,
    NVC_S_NVW   = 6'h20
  } nvc_state_t;

endpackage

//--- nvc_sync.sv
`timescale 1ns/1ps
module nvc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_i, // system clock
  input  wire logic             rst_i,     // sync reset, high
  input  wire logic [WIDTH-1:0] d_i,       // asynchronous inputs
  output logic      [WIDTH-1:0] q_o,       // third stage
  output logic      [WIDTH-1:0] stable_o   // stages two and three agree
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      q_o  <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      q_o  <= s2_r;
    end
  end

  assign stable_o = ~(s2_r ^ q_o);
endmodule

//--- nvc_host.sv
`timescale 1ns/1ps
module nvc_host #(
  parameter int STORE_CYC   = nvc_pkg::NVC_STORE_CYC,
  parameter int RESTORE_CYC = nvc_pkg::NVC_RESTORE_CYC
) (
  input  wire logic              sys_clk_i,     // 10 MHz clock
  input  wire logic              rst_i,         // sync reset, high
  input  wire logic              cmd_valid_i,   // command offered
  input  wire nvc_pkg::nvc_cmd_t cmd_i,         // command
  output logic                   cmd_ready_o,   // command taken when high
  output logic                   rsp_valid_o,   // one-cycle completion
  output logic                   rsp_err_o,     // refused or aborted
  output logic [7:0]             rsp_data_o,    // read data
  input  wire logic              power_good_i,  // supply above trip, pin
  output logic [14:0]            addr_o,        // address pins
  output logic                   cs_n_o,        // chip_select_low
  output logic                   oe_n_o,        // output_drive_low
  output logic                   we_n_o,        // write_strobe_low
  input  wire logic [7:0]        data_lines_i,  // data_lines in
  output logic [7:0]             data_lines_o,  // data_lines out
  output logic                   data_lines_oe_n_o // low while host drives
);
  localparam logic [nvc_pkg::NVC_TW-1:0] T_STORE   = nvc_pkg::NVC_TW'(STORE_CYC);
  localparam logic [nvc_pkg::NVC_TW-1:0] T_RECALL  = nvc_pkg::NVC_TW'(nvc_pkg::NVC_RECALL_CYC);
  localparam logic [nvc_pkg::NVC_TW-1:0] T_RESTORE = nvc_pkg::NVC_TW'(RESTORE_CYC);

  nvc_pkg::nvc_state_t         st_r;
  logic [nvc_pkg::NVC_TW-1:0]  tm_r;
  logic [2:0]                  acc_r;
  logic [2:0]                  idx_r;
  logic                        seq_r;
  logic                        store_r;
  logic                        wr_r;
  logic [8:0]                  sync_q;
  logic [8:0]                  sync_ok;
  logic                        pg_r;

  nvc_sync #(.WIDTH(9)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       ({power_good_i, data_lines_i}),
    .q_o       (sync_q),
    .stable_o  (sync_ok)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode
  // supply level only moves once stages two and three agree; a one-cycle dip is ignored
  wire       pg_w      = sync_ok[8] ? sync_q[8] : pg_r;
  wire [7:0] rd_w      = sync_q[7:0];
  wire       rd_ok_w   = &sync_ok[7:0];
  wire       take_w    = cmd_valid_i & cmd_ready_o;
  wire       is_nv_w   = cmd_i.op[1];
  wire       is_st_w   = cmd_i.op == nvc_pkg::NVC_OP_STORE;
  wire       refuse_w  = is_st_w & ~pg_w;
  wire       last_w    = idx_r == nvc_pkg::NVC_SEQ_LAST;
  wire       acc_done_w = (acc_r == 3'h0) & (wr_r | seq_r | rd_ok_w);
  wire [2:0] idx_nxt   = idx_r + 3'h1;
  // sixth word picks the transfer; bit 14 left low
  wire [13:0] sel_w    = (idx_nxt == 3'h1) ? nvc_pkg::NVC_SEQ_A1 :
                         (idx_nxt == 3'h2) ? nvc_pkg::NVC_SEQ_A2 :
                         (idx_nxt == 3'h3) ? nvc_pkg::NVC_SEQ_A3 :
                         (idx_nxt == 3'h4) ? nvc_pkg::NVC_SEQ_A4 :
                         store_r ? nvc_pkg::NVC_SEQ_STORE :
                         nvc_pkg::NVC_SEQ_RECALL;

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_r              <= nvc_pkg::NVC_S_PWR;
      tm_r              <= '0;
      acc_r             <= 3'h0;
      idx_r             <= 3'h0;
      seq_r             <= 1'b0;
      store_r           <= 1'b0;
      wr_r              <= 1'b0;
      pg_r              <= 1'b0;
      cmd_ready_o       <= 1'b0;
      rsp_valid_o       <= 1'b0;
      rsp_err_o         <= 1'b0;
      rsp_data_o        <= 8'h00;
      addr_o            <= 15'h0000;
      cs_n_o            <= 1'b1;
      oe_n_o            <= 1'b1;
      we_n_o            <= 1'b1;
      data_lines_o      <= 8'h00;
      data_lines_oe_n_o <= 1'b1;
    end else begin
      rsp_valid_o <= 1'b0;
      pg_r        <= pg_w;
      case (st_r)
        nvc_pkg::NVC_S_PWR: begin
          // strobe kept high while the power-up recall runs
          we_n_o <= 1'b1;
          if (!pg_w) begin
            tm_r <= '0;
          end else if (tm_r == T_RESTORE) begin
            st_r        <= nvc_pkg::NVC_S_IDLE;
            cmd_ready_o <= 1'b1;
          end else begin
            tm_r <= tm_r + 1'b1;
          end
        end
        nvc_pkg::NVC_S_IDLE: begin
          if (!pg_w && !take_w) begin
            // supply dipped: device will recall again on return
            st_r        <= nvc_pkg::NVC_S_PWR;
            tm_r        <= '0;
            cmd_ready_o <= 1'b0;
          end else if (take_w && refuse_w) begin
            rsp_valid_o <= 1'b1;
            rsp_err_o   <= 1'b1;
          end else if (take_w) begin
            cmd_ready_o       <= 1'b0;
            rsp_err_o         <= 1'b0;
            seq_r             <= is_nv_w;
            store_r           <= is_st_w;
            wr_r              <= cmd_i.op == nvc_pkg::NVC_OP_WRITE;
            idx_r             <= 3'h0;
            addr_o            <= is_nv_w ? {1'b0, nvc_pkg::NVC_SEQ_A0} : cmd_i.addr;
            data_lines_o      <= cmd_i.wdata;
            data_lines_oe_n_o <= cmd_i.op != nvc_pkg::NVC_OP_WRITE;
            st_r              <= nvc_pkg::NVC_S_SETUP;
          end
        end
        nvc_pkg::NVC_S_SETUP: begin
          // address settled a cycle before the select falls
          cs_n_o <= 1'b0;
          we_n_o <= ~wr_r;
          oe_n_o <= wr_r | seq_r;
          acc_r  <= nvc_pkg::NVC_ACC_CYC;
          st_r   <= nvc_pkg::NVC_S_ACC;
        end
        nvc_pkg::NVC_S_ACC: begin
          if (acc_r != 3'h0) begin
            acc_r <= acc_r - 3'h1;
          end else if (acc_done_w) begin
            cs_n_o     <= 1'b1;
            we_n_o     <= 1'b1;
            oe_n_o     <= 1'b1;
            rsp_data_o <= rd_w;
            st_r       <= nvc_pkg::NVC_S_HOLD;
          end
        end
        nvc_pkg::NVC_S_HOLD: begin
          // address and data held one cycle past the strobe rise
          data_lines_oe_n_o <= 1'b1;
          if (seq_r && !last_w) begin
            idx_r  <= idx_nxt;
            addr_o <= {1'b0, sel_w};
            st_r   <= nvc_pkg::NVC_S_SETUP;
          end else if (seq_r) begin
            tm_r  <= store_r ? T_STORE : T_RECALL;
            st_r  <= nvc_pkg::NVC_S_NVW;
          end else begin
            rsp_valid_o <= 1'b1;
            cmd_ready_o <= 1'b1;
            st_r        <= nvc_pkg::NVC_S_IDLE;
          end
        end
        nvc_pkg::NVC_S_NVW: begin
          // pins left idle for the whole transfer
          if (store_r && !pg_w) begin
            rsp_valid_o <= 1'b1;
            rsp_err_o   <= 1'b1;
            seq_r       <= 1'b0;
            tm_r        <= '0;
            st_r        <= nvc_pkg::NVC_S_PWR;
          end else if (tm_r == '0) begin
            rsp_valid_o <= 1'b1;
            seq_r       <= 1'b0;
            cmd_ready_o <= 1'b1;
            st_r        <= nvc_pkg::NVC_S_IDLE;
          end else begin
            tm_r <= tm_r - 1'b1;
          end
        end
        default: begin
          st_r <= nvc_pkg::NVC_S_PWR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_enter_nv;
    st_r == nvc_pkg::NVC_S_HOLD && seq_r && last_w;
  endsequence

  a_store_refused: assert property (
    take_w && st_r == nvc_pkg::NVC_S_IDLE && refuse_w |=> rsp_valid_o && rsp_err_o)
    else $error("store accepted while supply low");
  a_seq_strobe_high: assert property (
    seq_r && !cs_n_o |-> we_n_o)
    else $error("strobe low during sequence");
  a_write_drive_off: assert property (
    !we_n_o |-> oe_n_o && !data_lines_oe_n_o)
    else $error("output drive low during write");
  a_write_addr_hold: assert property (
    !cs_n_o && !we_n_o |=> $stable(addr_o))
    else $error("address moved during write");
  a_seq_first_word: assert property (
    st_r == nvc_pkg::NVC_S_SETUP && seq_r && idx_r == 3'h0
      |-> addr_o == {1'b0, nvc_pkg::NVC_SEQ_A0})
    else $error("sequence does not start at first word");
  a_sixth_word: assert property (
    st_r == nvc_pkg::NVC_S_SETUP && seq_r && last_w
      |-> addr_o[13:0] == (store_r ? nvc_pkg::NVC_SEQ_STORE : nvc_pkg::NVC_SEQ_RECALL))
    else $error("wrong sixth word");
  a_recall_quiet: assert property (
    s_enter_nv ##0 !store_r |=> (st_r == nvc_pkg::NVC_S_NVW && cs_n_o
      && data_lines_oe_n_o)[*8])
    else $error("pins active during recall");
  a_power_wait: assert property (
    st_r == nvc_pkg::NVC_S_PWR && !pg_w |=> st_r == nvc_pkg::NVC_S_PWR && !cmd_ready_o)
    else $error("left power wait with supply low");
  a_store_abort: assert property (
    st_r == nvc_pkg::NVC_S_NVW && store_r && !pg_w |=> st_r == nvc_pkg::NVC_S_PWR
      && rsp_valid_o && rsp_err_o)
    else $error("store not abandoned on low supply");
endmodule

//--- nvc_dev_model.sv
`timescale 1ns/1ps
module nvc_dev_model #(
  parameter int T_ST = 40,
  parameter int T_RC = 150
) (
  input  wire logic        sys_clk_i,    // sampling clock
  input  wire logic        power_good_i, // supply above trip
  input  wire logic [14:0] addr_i,       // address pins
  input  wire logic        cs_n_i,       // chip_select_low
  input  wire logic        oe_n_i,       // output_drive_low
  input  wire logic        we_n_i,       // write_strobe_low
  input  wire logic [7:0]  din_i,        // data_lines from host
  output logic      [7:0]  dout_o        // data_lines toward host
);
  logic [7:0]  mem    [32768];
  logic [7:0]  shadow [32768];
  logic [13:0] seq_now;
  logic [14:0] a_q;
  logic [7:0]  d_q;
  logic [7:0]  last = 8'h00;
  logic        cs_q = 1'b1;
  logic        pg_q = 1'b0;
  logic        wr_q = 1'b0;
  logic        storing = 1'b0;
  logic        drive;
  int          step = 0;
  int          busy = 0;
  initial foreach (shadow[i]) shadow[i] = 8'h00;
  assign seq_now = (step == 0) ? nvc_pkg::NVC_SEQ_A0 :
                   (step == 1) ? nvc_pkg::NVC_SEQ_A1 :
                   (step == 2) ? nvc_pkg::NVC_SEQ_A2 :
                   (step == 3) ? nvc_pkg::NVC_SEQ_A3 :
                   (step == 4) ? nvc_pkg::NVC_SEQ_A4 : 14'h0000;
  // released bus shows the inverse of the last byte, never a held value
  assign drive  = !cs_n_i && !oe_n_i && we_n_i && busy == 0 && power_good_i;
  assign dout_o = drive ? mem[addr_i] : ~last;
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    cs_q <= cs_n_i;
    pg_q <= power_good_i;
    if (drive) last <= dout_o;
    if (power_good_i && !pg_q) begin
      mem  <= shadow;
      busy <= 15;
    end else if (!power_good_i && storing) begin
      storing <= 1'b0;
      busy    <= 0;
    end else if (busy > 0) begin
      busy <= busy - 1;
      if (busy == 1 && storing) begin
        shadow  <= mem;
        storing <= 1'b0;
      end
    end else if (!cs_n_i) begin
      a_q <= addr_i;
      if (!we_n_i) begin
        wr_q <= 1'b1;
        d_q  <= din_i;
      end
    end else if (!cs_q) begin
      wr_q <= 1'b0;
      if (wr_q) begin
        mem[a_q] <= d_q;
        step     <= 0;
      end else if (step == 5 && a_q[13:0] == nvc_pkg::NVC_SEQ_STORE && power_good_i) begin
        storing <= 1'b1;
        busy    <= T_ST;
        step    <= 0;
      end else if (step == 5 && a_q[13:0] == nvc_pkg::NVC_SEQ_RECALL) begin
        mem  <= shadow;
        busy <= T_RC;
        step <= 0;
      end else if (step < 5 && a_q[13:0] == seq_now) begin
        step <= step + 1;
      end else begin
        step <= (a_q[13:0] == nvc_pkg::NVC_SEQ_A0) ? 1 : 0;
      end
    end
  end
endmodule

//--- tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
  logic              sys_clk_i    = 1'b0;
  logic              rst_i        = 1'b1;
  logic              cmd_valid_i  = 1'b0;
  logic              power_good_i = 1'b0;
  nvc_pkg::nvc_cmd_t cmd_i        = '0;
  logic              cmd_ready_o, rsp_valid_o, rsp_err_o;
  logic [7:0]        rsp_data_o, data_lines_o, dev_q;
  logic [14:0]       addr_o;
  logic              cs_n_o, oe_n_o, we_n_o, data_lines_oe_n_o;
  logic [7:0]        data_lines_i;
  logic              e;
  logic [7:0]        q;
  int                n_fail  = 0;
  int                checked = 0;
  int                n;
  assign data_lines_i = data_lines_oe_n_o ? dev_q : data_lines_o;
  initial forever #50 sys_clk_i = ~sys_clk_i;
  nvc_host #(.STORE_CYC(50), .RESTORE_CYC(20)) u_nvc_host (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o), .rsp_data_o(rsp_data_o),
    .power_good_i(power_good_i), .addr_o(addr_o), .cs_n_o(cs_n_o), .oe_n_o(oe_n_o),
    .we_n_o(we_n_o), .data_lines_i(data_lines_i), .data_lines_o(data_lines_o),
    .data_lines_oe_n_o(data_lines_oe_n_o));
  nvc_dev_model u_nvc_dev_model (.sys_clk_i(sys_clk_i), .power_good_i(power_good_i),
    .addr_i(addr_o), .cs_n_i(cs_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
    .din_i(data_lines_o), .dout_o(dev_q));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_hi(input bit rsp, input int lim, output int cnt);
    cnt = 0;
    while ((rsp ? rsp_valid_o : cmd_ready_o) !== 1'b1) begin
      @(negedge sys_clk_i);
      cnt++;
      if (cnt > lim) begin
        n_fail++;
        $display("[ERR] handshake wait exp 1 got timeout");
        close_out();
      end
    end
  endtask
  task automatic do_cmd(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d);
    int c;
    @(negedge sys_clk_i);
    cmd_valid_i = 1'b1;
    cmd_i       = {op, a, d};
    wait_hi(1'b0, 3000, c);
    @(negedge sys_clk_i);
    cmd_valid_i = 1'b0;
    wait_hi(1'b1, 5000, c);
    e = rsp_err_o;
    q = rsp_data_o;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenario: power rise, accesses held off for the restore time
  task automatic t_powerup();
    @(negedge sys_clk_i);
    power_good_i = 1'b1;
    wait_hi(1'b0, 500, n);
    `CHK("restore wait", 1'b1, n > 20)
  endtask
  // scenario: boundary addresses and the top address line stay distinct
  task automatic t_rw();
    logic [14:0] at [4] = '{15'h0000, 15'h7fff, 15'h4e38, 15'h0e38};
    foreach (at[i]) do_cmd(nvc_pkg::NVC_OP_WRITE, at[i], 8'h30 + 8'(i));
    foreach (at[i]) begin
      do_cmd(nvc_pkg::NVC_OP_READ, at[i], 8'h00);
      `CHK("read back", 8'h30 + 8'(i), q)
    end
  endtask
  // scenario: store, overwrite, recall twice
  task automatic t_nv();
    do_cmd(nvc_pkg::NVC_OP_WRITE, 15'h1234, 8'h5a);
    do_cmd(nvc_pkg::NVC_OP_STORE, 15'h0000, 8'h00);
    `CHK("store err", 1'b0, e)
    do_cmd(nvc_pkg::NVC_OP_WRITE, 15'h1234, 8'ha5);
    do_cmd(nvc_pkg::NVC_OP_READ, 15'h1234, 8'h00);
    `CHK("after store", 8'ha5, q)
    for (int k = 0; k < 2; k++) begin
      do_cmd(nvc_pkg::NVC_OP_RECALL, 15'h0000, 8'h00);
      do_cmd(nvc_pkg::NVC_OP_READ, 15'h1234, 8'h00);
      `CHK("recalled", 8'h5a, q)
    end
  endtask
  // scenario: supply drops in mid store; old shadow comes back at power-up
  task automatic t_abort();
    do_cmd(nvc_pkg::NVC_OP_WRITE, 15'h2000, 8'h11);
    fork
      do_cmd(nvc_pkg::NVC_OP_STORE, 15'h0000, 8'h00);
      begin
        repeat (60) @(negedge sys_clk_i);
        power_good_i = 1'b0;
      end
    join
    `CHK("store abort err", 1'b1, e)
    repeat (10) @(negedge sys_clk_i);
    t_powerup();
    do_cmd(nvc_pkg::NVC_OP_READ, 15'h2000, 8'h00);
    `CHK("aborted byte", 8'h00, q)
    do_cmd(nvc_pkg::NVC_OP_READ, 15'h1234, 8'h00);
    `CHK("kept byte", 8'h5a, q)
  endtask
  // scenario: store offered on the very edge the supply drop is seen; refused
  task automatic t_refuse();
    @(negedge sys_clk_i);
    power_good_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    do_cmd(nvc_pkg::NVC_OP_STORE, 15'h0000, 8'h00);
    `CHK("store refused", 1'b1, e)
    t_powerup();
    do_cmd(nvc_pkg::NVC_OP_READ, 15'h1234, 8'h00);
    `CHK("after refusal", 8'h5a, q)
  endtask
  initial begin
    repeat (16) @(negedge sys_clk_i);
    rst_i = 1'b0;
    t_powerup();
    t_rw();
    t_nv();
    t_abort();
    t_refuse();
    close_out();
  end
endmodule
